// ==== verilog/xbf_sequencer.sv ====
`timescale 1ns/1ps
`include "xbf_regs.svh"

// Notes on behaviour
// RQ1: Fast mode-0 is normal mode-0 minus 14 to 20 data-delay cycles.
// RQ2: Fast timing when transfer mode bit is 0 and speed bit is 1.
// RQ3: Turbo mode-0 cycle is seven clocks shorter than Fast mode-0.
// RQ4: Turbo timing when transfer mode is 0 and turbo select bit is 1.
// RQ5: Turbo read: address with data floated, select next clock, strobe after.
// RQ6: Turbo cycles ignore the ready input completely.
// RQ7: Turbo read samples data two clocks into strobe, then strobe, select end.
// RQ8: Turbo read holds address one clock past select, then zeroes it.
// RQ9: Turbo write: address and data, select next clock, write strobe after.
// RQ10: Turbo write strobe low three clocks, select off and float, address zero.
// RQ11: Mode-1 timing with enable and read/write when transfer mode is 1.
// RQ12: At least two idle bus clocks follow every cycle before the next.
// RQ13: Mode-1 read: enable low with address, select low ten clocks later.
// RQ14: Mode-1 read: enable high five clocks later for 18 plus waits.
// RQ15: Target drives read data while enable is high in mode-1.
// RQ16: Mode-1 enable low two clocks; data sampled one clock before fall.
// RQ17: Mode-1 read ends: select high, enable high, then address zero.
// RQ18: Mode-1 write: enable low with address, data; select and rw low later.
// RQ19: Mode-1 write enable high 18 plus waits, low two, then select high.
// RQ20: Mode-1 write ends: rw and enable high, then address zero.
// RQ21: Normal mode-0 waits on ready after 16 plus waits when enabled.
// RQ22: Normal mode-0 read: select one clock in, strobe three after select.
// RQ23: Fast mode removes cycles only from the pre-ready strobe phase.
// RQ24: Requests accepted only when idle; mode latched at request start.
module xbf_sequencer (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          reqValid,
  input  wire xbf_pkg::xbf_req_t             req,
  input  wire xbf_pkg::xbf_zone_cfg_t [3:0]  zoneCfg,
  input  wire logic [7:0]                    extDataIn,
  input  wire logic                          extReadyIn,
  output logic                               reqReady,
  output logic                               rspValid,
  output logic [7:0]                         rspData,
  output logic [11:0]                        extAddr,
  output logic [3:0]                         extChipSelectN,
  output logic                               readStrobeOrEnable,
  output logic                               writeStrobeOrRw,
  output logic [7:0]                         extDataOut,
  output logic                               extDataOe
);
  import xbf_pkg::*;

  xbf_state_t    state_r;
  xbf_mode_t     mode_r;
  xbf_plan_t     plan_r;
  logic [7:0]    cnt_r;
  logic [7:0]    cnt_nxt;
  logic [1:0]    gap_r;
  logic          write_r;
  logic [1:0]    chip_r;
  logic          useRdy_r;
  logic [7:0]    dataMeta_r;
  logic [7:0]    dataSync_r;
  logic          rdyMeta_r;
  logic          rdySync_r;
  logic          start;
  logic          stall;
  logic          running;
  xbf_mode_t     reqMode;
  xbf_zone_cfg_t reqCfg;

  // Turbo outranks the speed bit when both are set, since the faster
  // timing is the one a user selects on purpose.
  function automatic xbf_mode_t pickMode(input xbf_zone_cfg_t c);
    if (c.transferMode)
      pickMode = XBF_MODE1; // RQ11
    else if (c.turboSelect)
      pickMode = XBF_TURBO; // RQ4
    else if (c.transferSpeed)
      pickMode = XBF_FAST; // RQ2
    else
      pickMode = XBF_NORMAL;
  endfunction

  // All points are measured from the edge that drives the address. Each
  // one is the counter value at which a pin changes, ready is checked or data is sampled, and the counter only
  // stops while a mode-0 cycle waits on ready, so a stall shifts every
  // later point without any extra bookkeeping.
  // Fast mode removes cycles only between the strobe and the ready check.
  // That keeps the set-up of address, select and strobe as in normal
  // timing, which slow decoders on the far side may still rely on.
  // Turbo never stalls and ignores wait states, so its length is fixed.
  function automatic xbf_plan_t makePlan(input xbf_mode_t m,
                                         input logic [3:0] ws);
    xbf_plan_t  p;
    logic [7:0] w;
    w = {4'h0, ws};
    p = '0;
    case (m)
      XBF_MODE1: begin
        p.csOn   = `XBF_M1_CS_AT; // RQ13 RQ18
        p.stbOn  = p.csOn + `XBF_M1_CS_TO_EN; // RQ14 RQ19
        p.sample = p.stbOn + `XBF_M1_EN_HIGH + w - `XBF_ONE; // RQ16
        p.check  = p.sample;
        p.stbOff = p.sample + `XBF_ONE;
        p.csOff  = p.stbOff + `XBF_M1_EN_LOW; // RQ17 RQ19
        p.ctlOff = p.csOff + `XBF_ONE; // RQ17 RQ20
        p.done   = p.ctlOff + `XBF_ONE; // RQ17 RQ20
      end
      XBF_TURBO: begin
        // The wait-state count does not apply here.
        p.csOn   = `XBF_M0_CS_AT; // RQ5 RQ9
        p.stbOn  = p.csOn + `XBF_TB_CS_TO_STB; // RQ5 RQ9
        p.sample = p.stbOn + `XBF_TB_STB_TO_SMP; // RQ7
        p.check  = p.sample;
        p.stbOff = p.sample + `XBF_ONE; // RQ7 RQ10
        p.csOff  = p.stbOff + `XBF_ONE; // RQ7 RQ10
        p.ctlOff = p.stbOff;
        p.done   = p.csOff + `XBF_TB_ADDR_HOLD; // RQ3 RQ8 RQ10
      end
      default: begin
        p.csOn   = `XBF_M0_CS_AT;
        p.stbOn  = p.csOn + `XBF_M0_CS_TO_STB; // RQ22
        if (m == XBF_FAST)
          p.check = p.stbOn + `XBF_FAST_PRE_RDY + w; // RQ1 RQ23
        else
          p.check = p.stbOn + `XBF_NORM_PRE_RDY + w; // RQ21
        p.sample = p.check + `XBF_M0_RDY_TO_SMP;
        p.stbOff = p.sample + `XBF_ONE;
        p.csOff  = p.stbOff + `XBF_ONE;
        p.ctlOff = p.stbOff;
        p.done   = p.csOff + `XBF_M0_ADDR_HOLD;
      end
    endcase
    makePlan = p;
  endfunction

  function automatic logic hit(input logic [7:0] nxt,
                               input logic [7:0] pt);
    hit = (nxt == pt);
  endfunction

  assign reqCfg  = zoneCfg[req.chip];
  assign reqMode = pickMode(reqCfg);
  assign start   = (state_r == XBF_IDLE) && reqValid && reqReady; // RQ24
  assign running = (state_r == XBF_RUN);

  // Turbo and mode-1 never look at ready, so they cannot be stretched.
  // Ready passes two flops first, so a device that raises it just at the
  // check point still costs two clocks of stall. Faster tracking would
  // need the raw pin, which would risk a metastable decision here.
  assign stall = running && useRdy_r && (cnt_r == plan_r.check)
                 && !rdySync_r; // RQ6 RQ21
  assign cnt_nxt = stall ? cnt_r : cnt_r + `XBF_ONE;

  // Both pins are synchronised every clock, not only near the sample
  // point, so the capture never reads a value that skipped a flop.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdyMeta_r  <= 1'b0;
      rdySync_r  <= 1'b0;
      dataMeta_r <= 8'h00;
      dataSync_r <= 8'h00;
    end else begin
      rdyMeta_r  <= extReadyIn;
      rdySync_r  <= rdyMeta_r;
      dataMeta_r <= extDataIn;
      dataSync_r <= dataMeta_r;
    end
  end

  // The ready flag is registered and falls on the take edge itself, so a
  // request held high across that edge cannot be taken twice.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r  <= XBF_IDLE;
      reqReady <= 1'b0;
      gap_r    <= 2'h0;
    end else begin
      case (state_r)
        XBF_IDLE: begin
          if (start) begin
            state_r  <= XBF_RUN;
            reqReady <= 1'b0;
          end else begin
            reqReady <= 1'b1;
          end
        end
        XBF_RUN: begin
          if (hit(cnt_nxt, plan_r.done) && !stall) begin
            state_r <= XBF_GAP;
            gap_r   <= 2'h0;
          end
        end
        XBF_GAP: begin
          // Two quiet clocks follow every cycle, turbo included; slow
          // request traffic may add more, but never fewer.
          gap_r <= gap_r + 2'h1;
          if (gap_r == `XBF_IDLE_GAP - 2'h1) begin
            state_r  <= XBF_IDLE; // RQ12
            reqReady <= 1'b1;
          end
        end
        default: begin
          state_r  <= XBF_IDLE;
          reqReady <= 1'b0;
        end
      endcase
    end
  end

  // Mode and plan are frozen here so a config change mid-cycle is harmless.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_r   <= XBF_NORMAL;
      plan_r   <= '0;
      write_r  <= 1'b0;
      chip_r   <= 2'h0;
      useRdy_r <= 1'b0;
    end else if (start) begin
      mode_r   <= reqMode; // RQ24
      plan_r   <= makePlan(reqMode, reqCfg.waitStates);
      write_r  <= req.write;
      chip_r   <= req.chip;
      useRdy_r <= reqCfg.readyEnable
                  && (reqMode == XBF_NORMAL || reqMode == XBF_FAST);
    end
  end

  // The counter restarts on every take, so a count left from an earlier
  // cycle never lines up with the points of the new plan.
  always_ff @(posedge sys_clk) begin
    if (rst)
      cnt_r <= 8'h00;
    else if (start)
      cnt_r <= 8'h00;
    else if (running)
      cnt_r <= cnt_nxt;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extAddr <= 12'h000;
    end else if (start) begin
      extAddr <= req.addr; // RQ5 RQ13
    end else if (running && !stall && hit(cnt_nxt, plan_r.done)) begin
      extAddr <= 12'h000; // RQ8 RQ17 RQ20
    end
  end

  // Write data drives until select ends in mode 0 and until the rw line
  // rises in mode 1, so it is settled at every strobe or enable edge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extDataOut <= 8'h00;
      extDataOe  <= 1'b0;
    end else if (start) begin
      extDataOut <= req.wdata; // RQ9 RQ18
      extDataOe  <= req.write; // RQ5
    end else if (running && !stall) begin
      if (mode_r == XBF_MODE1) begin
        if (hit(cnt_nxt, plan_r.ctlOff))
          extDataOe <= 1'b0;
      end else if (hit(cnt_nxt, plan_r.csOff)) begin
        extDataOe <= 1'b0; // RQ10
      end
    end
  end

  // Only the chip latched at the take edge goes low; the others stay high
  // for the whole cycle, so two devices never answer on the bus at once.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extChipSelectN <= 4'hf;
    end else if (running && !stall) begin
      if (hit(cnt_nxt, plan_r.csOn))
        extChipSelectN <= ~(4'h1 << chip_r); // RQ5 RQ13 RQ18
      else if (hit(cnt_nxt, plan_r.csOff))
        extChipSelectN <= 4'hf; // RQ7 RQ10 RQ17 RQ19
    end
  end

  // In mode 1 this line is the enable, which idles high and drops at start.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readStrobeOrEnable <= 1'b1;
    end else if (start) begin
      readStrobeOrEnable <= (reqMode != XBF_MODE1); // RQ13 RQ18
    end else if (running && !stall) begin
      if (mode_r == XBF_MODE1) begin
        if (hit(cnt_nxt, plan_r.stbOn))
          readStrobeOrEnable <= 1'b1; // RQ14 RQ19
        else if (hit(cnt_nxt, plan_r.stbOff))
          readStrobeOrEnable <= 1'b0; // RQ16 RQ19
        else if (hit(cnt_nxt, plan_r.ctlOff))
          readStrobeOrEnable <= 1'b1; // RQ17 RQ20
      end else if (!write_r) begin
        // Mode-0 writes keep this strobe high; only reads pulse it.
        if (hit(cnt_nxt, plan_r.stbOn))
          readStrobeOrEnable <= 1'b0; // RQ5 RQ22
        else if (hit(cnt_nxt, plan_r.stbOff))
          readStrobeOrEnable <= 1'b1; // RQ7
      end
    end
  end

  // In mode 1 this line is a level across the select window; in mode 0
  // it is a strobe pulse inside that window.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      writeStrobeOrRw <= 1'b1;
    end else if (running && !stall && write_r) begin
      if (mode_r == XBF_MODE1) begin
        if (hit(cnt_nxt, plan_r.csOn))
          writeStrobeOrRw <= 1'b0; // RQ18
        else if (hit(cnt_nxt, plan_r.ctlOff))
          writeStrobeOrRw <= 1'b1; // RQ20
      end else begin
        if (hit(cnt_nxt, plan_r.stbOn))
          writeStrobeOrRw <= 1'b0; // RQ9
        else if (hit(cnt_nxt, plan_r.stbOff))
          writeStrobeOrRw <= 1'b1; // RQ10
      end
    end
  end

  // The data pins pass two flops first, so the value seen at the sample
  // edge reaches the sync stage two clocks later and is taken from there.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rspData <= 8'h00;
    end else if (running && !stall && !write_r
                 && hit(cnt_nxt, plan_r.sample + `XBF_SYNC_LAT)) begin
      rspData <= dataSync_r; // RQ7 RQ15 RQ16
    end
  end

  // Writes get the pulse too, so a caller can pace posted writes by it.

  always_ff @(posedge sys_clk) begin
    if (rst)
      rspValid <= 1'b0;
    else
      rspValid <= running && !stall && hit(cnt_nxt, plan_r.done);
  end

endmodule

// ==== verilog/xbf_regs.svh ====
`ifndef XBF_REGS_SVH
`define XBF_REGS_SVH

// Mode-0 cycle points, in clocks from the previous point; select from the address edge.
`define XBF_M0_CS_AT      8'h01
`define XBF_M0_CS_TO_STB  8'h03
`define XBF_TB_CS_TO_STB  8'h01
`define XBF_NORM_PRE_RDY  8'h10
`define XBF_FAST_PRE_RDY  8'h02
`define XBF_M0_RDY_TO_SMP 8'h04
`define XBF_TB_STB_TO_SMP 8'h02
`define XBF_M0_ADDR_HOLD  8'h02
`define XBF_TB_ADDR_HOLD  8'h01

// Mode-1 cycle points.
`define XBF_M1_CS_AT      8'h0a
`define XBF_M1_CS_TO_EN   8'h05
`define XBF_M1_EN_HIGH    8'h12
`define XBF_M1_EN_LOW     8'h02

// Shared steps.
`define XBF_ONE           8'h01
`define XBF_SYNC_LAT      8'h02
`define XBF_IDLE_GAP      2'h2

`endif

// ==== verilog/xbf_pkg.sv ====
package xbf_pkg;

  typedef enum logic [1:0] {
    XBF_NORMAL,
    XBF_FAST,
    XBF_TURBO,
    XBF_MODE1
  } xbf_mode_t;

  typedef enum logic [1:0] {
    XBF_IDLE,
    XBF_RUN,
    XBF_GAP
  } xbf_state_t;

  // Per chip-select configuration bits.
  typedef struct packed {
    logic       transferMode;
    logic       transferSpeed;
    logic       turboSelect;
    logic       readyEnable;
    logic [3:0] waitStates;
  } xbf_zone_cfg_t;

  typedef struct packed {
    logic        write;
    logic [1:0]  chip;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } xbf_req_t;

  // Cycle points of one transfer, counted from the address edge.
  typedef struct packed {
    logic [7:0] csOn;
    logic [7:0] stbOn;
    logic [7:0] check;
    logic [7:0] sample;
    logic [7:0] stbOff;
    logic [7:0] csOff;
    logic [7:0] ctlOff;
    logic [7:0] done;
  } xbf_plan_t;

endpackage

// ==== dv/xbf_sequencer_monitor.sv ====
`timescale 1ns/1ps
module xbf_sequencer_monitor (
  input wire logic                         sys_clk,
  input wire logic                         rst,
  input wire logic                         reqValid,
  input wire xbf_pkg::xbf_req_t            req,
  input wire xbf_pkg::xbf_zone_cfg_t [3:0] zoneCfg,
  input wire logic                         reqReady,
  input wire logic                         rspValid,
  input wire logic [11:0]                  extAddr,
  input wire logic [3:0]                   extChipSelectN,
  input wire logic                         readStrobeOrEnable,
  input wire logic                         writeStrobeOrRw,
  input wire logic                         extDataOe
);
  import xbf_pkg::*;
  xbf_zone_cfg_t c;
  logic          take, csIdle, m1_r, tb_r, wr_r, stall_r, busy_r;
  logic [7:0]    ws, cnt_r, expD_r;
  assign c = zoneCfg[req.chip];
  assign take = reqValid && reqReady;
  assign csIdle = &extChipSelectN;
  assign ws = {4'h0, c.waitStates};
  // At each sample the count equals the edge index of the visible outputs.
  always_ff @(posedge sys_clk) begin
    cnt_r <= take ? 8'h00 : cnt_r + {7'h00, cnt_r != 8'hff};
  end
  always_ff @(posedge sys_clk) begin
    busy_r <= !rst && (take || (busy_r && !rspValid));
  end
  // Ready stalls make normal and fast lengths open, so those with ready enabled are skipped.
  always_ff @(posedge sys_clk) begin
    if (take) begin
      m1_r    <= c.transferMode;
      tb_r    <= !c.transferMode && c.turboSelect;
      wr_r    <= req.write;
      stall_r <= !c.transferMode && !c.turboSelect && c.readyEnable;
      expD_r  <= c.transferMode ? ws + 8'h25 : c.turboSelect ? 8'h07 :
                 ws + (c.transferSpeed ? 8'h0e : 8'h1c);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence turboRd;
    csIdle ##1 (!csIdle && readStrobeOrEnable) ##1 !readStrobeOrEnable [*3]
    ##1 (readStrobeOrEnable && !csIdle) ##1 csIdle
    ##1 (rspValid && extAddr == 12'h000);
  endsequence
  sequence turboWr;
    (extDataOe && csIdle) ##1 (!csIdle && writeStrobeOrRw)
    ##1 !writeStrobeOrRw [*3] ##1 (writeStrobeOrRw && extDataOe && !csIdle)
    ##1 (csIdle && !extDataOe) ##1 (rspValid && extAddr == 12'h000);
  endsequence
  sequence mode1Tail;
    (!readStrobeOrEnable && writeStrobeOrRw != wr_r) [*2]
    ##1 (csIdle && !readStrobeOrEnable)
    ##1 (readStrobeOrEnable && writeStrobeOrRw)
    ##1 (rspValid && extAddr == 12'h000);
  endsequence
  done_time_a:
    assert property (busy_r && rspValid && !stall_r |-> cnt_r == expD_r)
    else $error("transfer length wrong");
  select_on_a:
    assert property (busy_r && $fell(csIdle) |-> cnt_r == (m1_r ? 8'h0a : 8'h01))
    else $error("select edge wrong");
  strobe_on_a:
    assert property (busy_r && !m1_r && $fell(readStrobeOrEnable &&
      writeStrobeOrRw) |-> cnt_r == (tb_r ? 8'h02 : 8'h04))
    else $error("strobe edge wrong");
  turbo_read_a:
    assert property (take && !c.transferMode && c.turboSelect && !req.write
      |=> turboRd) else $error("turbo read walk wrong");
  turbo_write_a:
    assert property (take && !c.transferMode && c.turboSelect && req.write
      |=> turboWr) else $error("turbo write walk wrong");
  enable_phase_a:
    assert property (busy_r && m1_r && cnt_r < expD_r - 8'h04
      |-> readStrobeOrEnable == (cnt_r > 8'h0e)) else $error("enable wrong");
  mode1_tail_a:
    assert property (busy_r && m1_r && cnt_r == expD_r - 8'h04 |-> mode1Tail)
    else $error("mode1 ending wrong");
  idle_gap_a:
    assert property (rspValid |-> !reqReady ##1 !reqReady ##1 reqReady)
    else $error("idle gap wrong");
endmodule

bind xbf_sequencer xbf_sequencer_monitor mon (.*);

// ==== dv/xbf_ext_device.sv ====
`timescale 1ns/1ps
module xbf_ext_device (
  input  wire logic        sys_clk,
  input  wire logic        m1,
  input  wire logic [3:0]  stall,
  input  wire logic [11:0] extAddr,
  input  wire logic [3:0]  extChipSelectN,
  input  wire logic        readStrobeOrEnable,
  input  wire logic        writeStrobeOrRw,
  input  wire logic [7:0]  extDataOut,
  output logic      [7:0]  extDataIn = 8'h00,
  output logic             extReadyIn = 1'b0,
  output logic      [7:0]  wrSeen = 8'h00
);
  logic [7:0] pat_r = 8'h00;
  logic [7:0] wait_r = 8'h00;
  logic       sel, rd;
  assign sel = !(&extChipSelectN);
  assign rd = sel && writeStrobeOrRw && (m1 == readStrobeOrEnable);
  // Undriven lines wander each clock, so a mistimed sample cannot match.
  always_ff @(posedge sys_clk) begin
    pat_r <= pat_r + 8'h3b;
    extDataIn <= rd ? extAddr[7:0] ^ 8'h5a : ~pat_r;
    wait_r <= sel ? wait_r + 8'h01 : 8'h00;
    extReadyIn <= sel && wait_r >= {4'h0, stall};
    if (sel && !writeStrobeOrRw) begin
      wrSeen <= extDataOut;
    end
  end
endmodule

// ==== dv/xbf_sequencer_tb.sv ====
`timescale 1ns/1ps
module xbf_sequencer_tb;
  import xbf_pkg::*;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic                reqValid = 1'b0;
  xbf_req_t            req = '0;
  xbf_zone_cfg_t [3:0] zoneCfg = '0;
  logic                m1 = 1'b0;
  logic [3:0]          stall = 4'h0;
  logic [7:0]          extDataIn, rspData, extDataOut, wrSeen;
  logic [11:0]         extAddr;
  logic [3:0]          extChipSelectN;
  logic                extReadyIn, reqReady, rspValid, extDataOe;
  logic                readStrobeOrEnable, writeStrobeOrRw;
  int                  errTotal = 0;
  int                  totalChecks = 0;
  int                  cycles = 0;

  always #5 sys_clk = ~sys_clk;

  xbf_sequencer uut (.*);
  xbf_ext_device dev (.*);

  task automatic testDone;
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [11:0] seen,
                       input logic [11:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] expLen(input logic [1:0] m,
                                        input logic [3:0] ws);
    return m == 2'h2 ? 8'h07 : {4'h0, ws} + (m == 2'h3 ? 8'h25 :
           m == 2'h1 ? 8'h0e : 8'h1c);
  endfunction

  // Mode code: 0 normal, 1 fast, 2 turbo, 3 mode1; other bits stay random.
  task automatic xfer(input logic [1:0] m, input logic w,
                      input logic [3:0] ws, input logic [3:0] st);
    xbf_zone_cfg_t zc;
    xbf_req_t      rq;
    logic [7:0]    n;
    zc = xbf_zone_cfg_t'($urandom);
    rq = xbf_req_t'($urandom);
    rq.write = w;
    zc.transferMode = m == 2'h3;
    zc.waitStates = ws;
    if (m != 2'h3) zc.turboSelect = m == 2'h2;
    if (m < 2'h2) zc.transferSpeed = m[0];
    if (st != 4'h0) zc.readyEnable = 1'b1;
    zoneCfg[rq.chip] = zc;
    m1 = zc.transferMode;
    stall = st;
    req = rq;
    reqValid = 1'b1;
    while (!reqReady) @(negedge sys_clk);
    @(negedge sys_clk);
    reqValid = 1'b0;
    n = 8'h00;
    while (!rspValid && n < 8'hc8) begin
      @(negedge sys_clk);
      n++;
    end
    if (st != 4'h0 && !m[1]) check("stall", {11'h0, n > expLen(m, ws)}, 12'h1);
    else check("length", {4'h0, n}, {4'h0, expLen(m, ws)});
    if (w) check("wdata", {4'h0, wrSeen}, {4'h0, rq.wdata});
    else check("rdata", {4'h0, rspData}, {4'h0, rq.addr[7:0] ^ 8'h5a});
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      errTotal++;
      testDone;
    end
  end

  initial begin
    void'($urandom(4));
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    for (int i = 0; i < 32; i++) begin
      xfer(i[1:0], i[2], i < 8 ? 4'h0 : 4'($urandom), 4'h0);
    end
    for (int i = 0; i < 4; i++) begin
      xfer(i[1:0], i[0], 4'hf, 4'h0);
    end
    xfer(2'h2, 1'b0, 4'h0, 4'hf);
    xfer(2'h2, 1'b1, 4'h0, 4'hf);
    xfer(2'h1, 1'b0, 4'h0, 4'hf);
    xfer(2'h1, 1'b1, 4'h3, 4'hf);
    testDone;
  end
endmodule
